// ==== design/lamp_pdwn_defs.vh ====
// Constants for the lamp and power-down register bank
`ifndef LAMP_PDWN_DEFS_VH
`define LAMP_PDWN_DEFS_VH
// Register addresses
`define ADDR_IRIS_POWER        6'h0B
`define ADDR_LED_B_SETTING     6'h24
`define ADDR_LED_A_SETTING     6'h29
// Field positions within the 16-bit data word
`define BIT_IRIS_POWER_ENABLE  10
`define BIT_LAMP_CONTROL       11
// Reset values
`define RST_IRIS_POWER_ENABLE  1'b0
`define RST_LAMP_CONTROL       1'b0
// Serial frame layout, least significant bit first
`define FRAME_ADDR_BITS        6
`define FRAME_RW_POS           6
`define FRAME_DATA_START       8
`define FRAME_BITS             24
// Oscillation watchdog on the system clock input: 640 ns at 10 ns a clock
`define CLOCK_PERIOD_NS        10
`define OSC_TIMEOUT_NS         640
`define OSC_TIMEOUT_CYCLES     8'h40
`endif

// ==== design/pin_sync.v ====
// Two-stage synchroniser for the asynchronous input pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input  wire       clock_i,
    input  wire       rst_n_i,
    input  wire [5:0] async_i,
    output reg  [5:0] sync_o
);
    reg [5:0] meta;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= 6'h00;
            sync_o <= 6'h00;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== design/led_output_and_power_down_control.v ====
// Serial register slave for lamp outputs and iris power-down
`timescale 1ns/100ps
`default_nettype none
`include "lamp_pdwn_defs.vh"
module led_output_and_power_down_control (
    input  wire clock_i,
    input  wire rst_n_i,
    input  wire system_clock_input_i,
    input  wire serial_select_i,
    input  wire serial_clock_i,
    input  wire serial_data_i,
    input  wire focus_frame_sync_i,
    input  wire iris_frame_sync_i,
    output reg  serial_data_o,
    output reg  serial_data_oe_o,
    output reg  first_lamp_control_o,
    output reg  second_lamp_control_o,
    output reg  iris_drive_run_o,
    output reg  power_down_o,
    output reg  microstep_run_o,
    output reg  focus_frame_sync_o,
    output reg  iris_frame_sync_o,
    output reg  osc_present_o
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    wire [5:0] pins_sync;

    pin_sync u_pin_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({iris_frame_sync_i, focus_frame_sync_i, system_clock_input_i,
                   serial_data_i, serial_clock_i, serial_select_i}),
        .sync_o  (pins_sync)
    );

    wire cs_s   = pins_sync[0];
    wire sck_s  = pins_sync[1];
    wire sin_s  = pins_sync[2];
    wire osc_s  = pins_sync[3];
    wire fsf_s  = pins_sync[4];
    wire fsi_s  = pins_sync[5];

    // ----------------------------------------------------------------
    // Edge detection on the synchronised pins
    // ----------------------------------------------------------------
    reg cs_d;
    reg sck_d;
    reg osc_d;

    // Reset to the idle levels, so no false edge follows reset
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_d  <= 1'b0;
            sck_d <= 1'b0;
            osc_d <= 1'b0;
        end else begin
            cs_d  <= cs_s;
            sck_d <= sck_s;
            osc_d <= osc_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_fall  = ~cs_s & cs_d;

    // ----------------------------------------------------------------
    // Frame-sync outputs
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            focus_frame_sync_o <= 1'b0;
            iris_frame_sync_o  <= 1'b0;
        end else begin
            focus_frame_sync_o <= fsf_s;
            iris_frame_sync_o  <= fsi_s;
        end
    end

    // ----------------------------------------------------------------
    // Oscillation watchdog
    // ----------------------------------------------------------------
    // Flag drops once the pin has stayed still for the timeout
    localparam [7:0] OSC_LIMIT = `OSC_TIMEOUT_CYCLES;
    reg [7:0] osc_idle;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_idle      <= 8'h00;
            osc_present_o <= 1'b0;
        end else if (osc_s != osc_d) begin
            osc_idle      <= 8'h00;
            osc_present_o <= 1'b1;
        end else if (osc_idle >= OSC_LIMIT) begin
            osc_present_o <= 1'b0;
        end else begin
            osc_idle <= osc_idle + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Serial frame receiver
    // ----------------------------------------------------------------
    reg [23:0] shift_in;
    reg [4:0]  bit_count;
    reg        frame_bad;
    reg [15:0] shift_out;
    reg        reading;

    reg        iris_power_enable;

    function [15:0] read_word;
        input [5:0] addr;
        begin
            read_word = 16'h0000;
            case (addr)
                `ADDR_LED_A_SETTING: read_word[`BIT_LAMP_CONTROL] = first_lamp_control_o;
                `ADDR_LED_B_SETTING: read_word[`BIT_LAMP_CONTROL] = second_lamp_control_o;
                `ADDR_IRIS_POWER:    read_word[`BIT_IRIS_POWER_ENABLE] = iris_power_enable;
                default:             read_word = 16'h0000;
            endcase
        end
    endfunction

    // Frame, first bit first: address, read flag, spare, 16 data bits
    wire [23:0] next_shift = {sin_s, shift_in[23:1]};
    wire [5:0]  frame_addr = shift_in[`FRAME_ADDR_BITS-1:0];
    wire        frame_rd   = shift_in[`FRAME_RW_POS];
    wire [15:0] frame_data = shift_in[`FRAME_BITS-1:`FRAME_DATA_START];
    // Writes land only after a clean frame of 24 or more clocks; bits past the 24th are ignored
    wire        commit     = cs_fall & ~frame_bad & ~frame_rd
                             & (bit_count == 5'd`FRAME_BITS);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_in  <= 24'h00_0000;
            bit_count <= 5'h00;
            frame_bad <= 1'b0;
            shift_out <= 16'h0000;
            reading   <= 1'b0;
        end else if (!cs_s) begin
            bit_count <= 5'h00;
            frame_bad <= 1'b0;
            reading   <= 1'b0;
        end else begin
            // A frame that saw the clock missing is discarded
            if (!osc_present_o) begin
                frame_bad <= 1'b1;
            end
            if (sck_rise && bit_count < 5'd`FRAME_BITS) begin
                shift_in  <= next_shift;
                bit_count <= bit_count + 5'h01;
                // Eighth bit in: frame bits 0 to 7 sit at [23:16]
                if (bit_count == 5'd7 && next_shift[22]) begin
                    reading   <= 1'b1;
                    shift_out <= read_word(next_shift[21:16]);
                end
            end
            // Next read bit after each falling serial clock from the ninth on
            if (sck_fall && reading && bit_count > 5'd8) begin
                shift_out <= {1'b0, shift_out[15:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data output
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_data_o    <= 1'b0;
            serial_data_oe_o <= 1'b0;
        end else begin
            serial_data_o    <= shift_out[0];
            // Enable drops once the frame closes or goes bad
            serial_data_oe_o <= cs_s & reading & ~frame_bad;
        end
    end

    // ----------------------------------------------------------------
    // Register bank and drive outputs
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_lamp_control_o  <= `RST_LAMP_CONTROL;
            second_lamp_control_o <= `RST_LAMP_CONTROL;
            iris_power_enable     <= `RST_IRIS_POWER_ENABLE;
        end else if (commit) begin
            case (frame_addr)
                `ADDR_LED_A_SETTING: first_lamp_control_o  <= frame_data[`BIT_LAMP_CONTROL];
                `ADDR_LED_B_SETTING: second_lamp_control_o <= frame_data[`BIT_LAMP_CONTROL];
                `ADDR_IRIS_POWER:    iris_power_enable <= frame_data[`BIT_IRIS_POWER_ENABLE];
                // Unmapped addresses leave every setting alone
                default:             iris_power_enable <= iris_power_enable;
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iris_drive_run_o <= `RST_IRIS_POWER_ENABLE;
            power_down_o     <= ~`RST_IRIS_POWER_ENABLE;
            microstep_run_o  <= 1'b0;
        end else begin
            // Micro-step drive is never gated by power-down
            iris_drive_run_o <= iris_power_enable;
            power_down_o     <= ~iris_power_enable;
            microstep_run_o  <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/lamp_host.sv ====
// Host side serial master model
`timescale 1ns/100ps
`default_nettype none
module lamp_host (
    input  wire logic clock_i,
    input  wire logic sdo_i,
    output var  logic sel_o,
    output var  logic sclk_o,
    output var  logic sdi_o
);
    initial {sel_o, sclk_o, sdi_o} = 3'h0;
    // One frame, LSB first; h clocks per clock half
    task automatic xfer(input logic [23:0] f, input int h, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clock_i) #1 sel_o = 1'b1;
        for (int i = 0; i < 24; i++) begin
            sdi_o = f[i];
            repeat (h) @(posedge clock_i);
            #1 sclk_o = 1'b1;
            if (i > 7) rd[i-8] = sdo_i;
            repeat (h) @(posedge clock_i);
            #1 sclk_o = 1'b0;
        end
        repeat (h) @(posedge clock_i);
        #1 sel_o = 1'b0;
        sdi_o = ~f[23];
        repeat (12) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// ==== tb/lamp_pdwn_properties.sv ====
// Port assertions for the lamp and power-down bank
`timescale 1ns/100ps
`default_nettype none
module lamp_pdwn_properties (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic system_clock_input_i,
    input wire logic serial_select_i,
    input wire logic focus_frame_sync_i,
    input wire logic iris_frame_sync_i,
    input wire logic serial_data_oe_o,
    input wire logic first_lamp_control_o,
    input wire logic second_lamp_control_o,
    input wire logic iris_drive_run_o,
    input wire logic power_down_o,
    input wire logic microstep_run_o,
    input wire logic focus_frame_sync_o,
    input wire logic iris_frame_sync_o,
    input wire logic osc_present_o
);
    logic       osc_q;
    logic [7:0] idle_cnt;
    // Cycles since the oscillator pin last moved
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_q <= 1'b0;
            idle_cnt <= 8'h00;
        end else begin
            osc_q <= system_clock_input_i;
            if (osc_q != system_clock_input_i) idle_cnt <= 8'h00;
            else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_MS_RUN: assert property (1'b1 |=> microstep_run_o)
        else $error("microstep drive stopped");
    AST_PD_INV: assert property (power_down_o != iris_drive_run_o)
        else $error("power down not inverse of iris run");
    AST_F_SYNC: assert property ($past(rst_n_i, 3) |-> focus_frame_sync_o == $past(focus_frame_sync_i, 3))
        else $error("focus sync latency wrong");
    AST_I_SYNC: assert property ($past(rst_n_i, 3) |-> iris_frame_sync_o == $past(iris_frame_sync_i, 3))
        else $error("iris sync latency wrong");
    AST_LAMP_RST: assert property ($rose(rst_n_i) |-> !first_lamp_control_o && !second_lamp_control_o)
        else $error("lamp on after reset");
    AST_OSC_TMO: assert property (idle_cnt > 8'h42 |-> !osc_present_o)
        else $error("oscillation flag stuck");
    AST_LAMP_SEL: assert property ($changed(first_lamp_control_o) || $changed(second_lamp_control_o)
        |-> !serial_select_i)
        else $error("lamp changed inside frame");
    AST_OE_OSC: assert property ($rose(serial_data_oe_o) |-> $past(osc_present_o))
        else $error("read answered without clock");
    cover property ($rose(first_lamp_control_o));
    cover property ($fell(power_down_o));
    cover property ($rose(serial_data_oe_o));
endmodule
bind led_output_and_power_down_control lamp_pdwn_properties chk (
    .clock_i               (clock_i),
    .rst_n_i               (rst_n_i),
    .system_clock_input_i  (system_clock_input_i),
    .serial_select_i       (serial_select_i),
    .focus_frame_sync_i    (focus_frame_sync_i),
    .iris_frame_sync_i     (iris_frame_sync_i),
    .serial_data_oe_o      (serial_data_oe_o),
    .first_lamp_control_o  (first_lamp_control_o),
    .second_lamp_control_o (second_lamp_control_o),
    .iris_drive_run_o      (iris_drive_run_o),
    .power_down_o          (power_down_o),
    .microstep_run_o       (microstep_run_o),
    .focus_frame_sync_o    (focus_frame_sync_o),
    .iris_frame_sync_o     (iris_frame_sync_o),
    .osc_present_o         (osc_present_o)
);
`default_nettype wire

// ==== tb/test_led_output_and_power_down_control.sv ====
// Self-checking bench for the lamp and power-down bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module test_led_output_and_power_down_control;
    logic        clock_i = 0, rst_n_i = 0, osc = 0, osc_on = 1, fs_f = 0, fs_i = 0;
    wire         sel, sclk, sdi, sdo, oe, la, lb, run, pd, ms, ffo, ifo, op;
    int          err_total = 0, samples_checked = 0, seed = 95, m_a = 0, m_b = 0, m_e = 0;
    logic [15:0] rd;
    logic        qf, qi;
    logic        fq[$], iq[$];
    logic [5:0]  ad [4] = '{6'h0B, 6'h24, 6'h29, 6'h15};
    // Released read line shows the inverse of its last bit
    lamp_host host (.clock_i(clock_i), .sdo_i(oe ? sdo : ~sdo), .sel_o(sel), .sclk_o(sclk), .sdi_o(sdi));
    led_output_and_power_down_control dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .system_clock_input_i(osc),
        .serial_select_i(sel), .serial_clock_i(sclk), .serial_data_i(sdi), .focus_frame_sync_i(fs_f),
        .iris_frame_sync_i(fs_i), .serial_data_o(sdo), .serial_data_oe_o(oe), .first_lamp_control_o(la),
        .second_lamp_control_o(lb), .iris_drive_run_o(run), .power_down_o(pd), .microstep_run_o(ms),
        .focus_frame_sync_o(ffo), .iris_frame_sync_o(ifo), .osc_present_o(op));
    initial forever #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (osc_on) osc <= #1 ~osc;
        fs_f <= #1 1'($random(seed));
        fs_i <= #1 1'($random(seed));
    end
    // Frame-sync model: three clocks from pin to output
    always @(negedge clock_i) begin
        if (!rst_n_i) begin
            fq.delete();
            iq.delete();
        end else begin
            fq.push_back(fs_f);
            iq.push_back(fs_i);
            if (fq.size() > 3) begin
                qf = fq.pop_front();
                qi = iq.pop_front();
                `CHK("focus_sync", qf, ffo)
                `CHK("iris_sync", qi, ifo)
            end
        end
    end
    function automatic logic [15:0] expect_rd(input logic [5:0] a);
        return a == 6'h29 ? 16'(m_a) << 11 : a == 6'h24 ? 16'(m_b) << 11 : a == 6'h0B ? 16'(m_e) << 10 : 16'h0000;
    endfunction
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check_all();
        `CHK("lamp_a", m_a[0], la)
        `CHK("lamp_b", m_b[0], lb)
        `CHK("iris_run", m_e[0], run)
        `CHK("power_down", !m_e[0], pd)
        `CHK("microstep", 1'b1, ms)
    endtask
    // Write, check outputs, read back
    task automatic access(input logic [5:0] a, input logic [15:0] d, input int h);
        host.xfer({d, 2'b00, a}, h, rd);
        if (osc_on) begin
            if (a == 6'h29) m_a = d[11];
            if (a == 6'h24) m_b = d[11];
            if (a == 6'h0B) m_e = d[10];
        end
        check_all();
        host.xfer({16'h0000, 2'b01, a}, h, rd);
        if (osc_on) `CHK("read_back", expect_rd(a), rd)
    endtask
    initial begin
        repeat (90000) @(posedge clock_i);
        err_total++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clock_i);
        #1 rst_n_i = 1;
        repeat (10) @(posedge clock_i);
        check_all();
        for (int i = 0; i < 40; i++)
            access(ad[$unsigned($random(seed)) % 4], 16'($random(seed)), 10 + 10 * (i % 2));
        access(6'h29, 16'h0800, 10);
        access(6'h24, 16'h0800, 10);
        #1 rst_n_i = 0;
        repeat (4) @(posedge clock_i);
        #1 rst_n_i = 1;
        m_a = 0;
        m_b = 0;
        m_e = 0;
        repeat (10) @(posedge clock_i);
        check_all();
        osc_on = 0;
        repeat (80) @(posedge clock_i);
        `CHK("osc_present", 1'b0, op)
        access(6'h29, ~(16'(m_a) << 11), 10);
        osc_on = 1;
        repeat (10) @(posedge clock_i);
        `CHK("osc_present", 1'b1, op)
        access(6'h0B, 16'h0000, 10);
        close_out();
    end
endmodule
`default_nettype wire
